/* rtl/umf_top.sv */
`timescale 1ns/1ps
module umf_top import umf_pkg::*; (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // modem pins, active low
   input wire logic [3:0] i_cts_n,
   input wire logic [3:0] i_dsr_n,
   input wire logic [3:0] i_ri_n,
   output logic [3:0] o_dtr_n,
   output logic [3:0] o_rts_n,
   // serial pins
   input wire logic [3:0] i_sin,
   output logic [3:0] o_sout,
   // transmitter side
   input wire logic [3:0] i_tx_bit,
   input wire logic [3:0] i_tx_bit_start,
   input wire logic [3:0] i_tx_empty,
   input wire logic [3:0] i_tx_flow_char,
   input wire logic [3:0] i_tx_tick_int,
   input wire logic [3:0] i_tx_tick_nx,
   input wire logic [3:0] i_tx_tick16,
   output logic [3:0] o_tx_start_ok,
   output logic [3:0] o_tx_tick,
   // receiver side
   input wire logic [3:0] i_rx_tick_int,
   input wire logic [3:0] i_rx_tick16,
   input wire logic [3:0][7:0] i_rx_level,
   output logic [3:0] o_rx_tick,
   output logic [3:0] o_rx_bit,
   // fifo size
   input wire logic i_fifo_size_select,
   input wire logic [3:0] i_fifo_force128,
   input wire logic [3:0] i_enhanced,
   output logic [3:0][7:0] o_fifo_depth,
   // per-channel configuration
   input wire logic [3:0] i_auto_dtr,
   input wire logic [3:0] i_auto_rts,
   input wire logic [3:0] i_auto_cts,
   input wire logic [3:0] i_auto_dsr,
   input wire logic [3:0][7:0] i_thr_upper,
   input wire logic [3:0][7:0] i_thr_lower,
   input wire logic [3:0][1:0] i_additional_control_reg_dtr,
   input wire logic [3:0][7:0] i_clock_select_reg,
   input wire logic [3:0][7:0] i_modem_control_reg,
   // modem status
   output logic [3:0] o_ring_present
);
   // =========================================================
   // per-channel decode
   logic [3:0] rx_ext;
   logic [3:0] rx_from_tx;
   logic [3:0] tx_ext;
   logic [3:0] rx_rise;
   logic [3:0] tx_rise;
   logic [3:0] at_upper;
   logic [3:0] below_lower;
   logic [3:0] irda_en;
   logic [3:0][1:0] dtr_clk_sel;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         assign rx_ext[g] = i_clock_select_reg[g][CLK_SEL_RX_LO +: 2]
            == CLK_SEL_RX_EXT;
         assign rx_from_tx[g] = i_clock_select_reg[g][CLK_SEL_RX_LO +: 2]
            == CLK_SEL_RX_FROM_TX;
         assign tx_ext[g] = i_clock_select_reg[g][CLK_SEL_TX_EXT_BIT];
         assign dtr_clk_sel[g] = i_clock_select_reg[g][CLK_SEL_DTR_LO +: 2];
         // thresholds are per channel, ports of this channel only
         assign at_upper[g] = i_rx_level[g] >= i_thr_upper[g];
         assign below_lower[g] = i_rx_level[g] < i_thr_lower[g];
         assign irda_en[g] =
            i_modem_control_reg[g][MODEM_CTL_IR_BIT] & i_enhanced[g];

         // dsr pin doubles as receive clock
         umf_pin_edge u_rx_edge (
            .i_clk_sys(i_clk_sys),
            .i_srst(i_srst),
            .i_pin(i_dsr_n[g]),
            .o_rise(rx_rise[g])
         );

         // ri pin doubles as transmit clock
         umf_pin_edge u_tx_edge (
            .i_clk_sys(i_clk_sys),
            .i_srst(i_srst),
            .i_pin(i_ri_n[g]),
            .o_rise(tx_rise[g])
         );

         umf_irda u_irda (
            .i_clk_sys(i_clk_sys),
            .i_srst(i_srst),
            .i_en(irda_en[g]),
            .i_tx_tick16(i_tx_tick16[g]),
            .i_rx_tick16(i_rx_tick16[g]),
            .i_bit_start(i_tx_bit_start[g]),
            .i_tx_bit(i_tx_bit[g]),
            .i_sin(i_sin[g]),
            .o_sout(o_sout[g]),
            .o_rx_bit(o_rx_bit[g])
         );
      end
   endgenerate

   // =========================================================
   // channel state
   umf_top_st_t s_q;
   umf_top_st_t s_d;

   always_comb begin
      s_d = s_q;
      for (int c = 0; c < NUM_CH; c++) begin
         // fifo depth from pin, force bit or enhanced mode
         if (i_fifo_size_select | i_fifo_force128[c] | i_enhanced[c]) begin
            s_d.depth[c] = DEPTH_BIG;
         end else begin
            s_d.depth[c] = DEPTH_SMALL;
         end
         // hysteresis: between the thresholds the level holds
         if (at_upper[c]) begin
            s_d.dtr_flow[c] = 1'b1;
            s_d.rts_flow[c] = 1'b0;
         end else if (below_lower[c]) begin
            s_d.dtr_flow[c] = 1'b0;
            s_d.rts_flow[c] = 1'b1;
         end
         // dsr flow is ignored while the pin carries a clock
         s_d.stop[c] = (i_auto_cts[c] & i_cts_n[c]) |
            (i_auto_dsr[c] & ~rx_ext[c] & i_dsr_n[c]);
         // clock sources
         if (tx_ext[c]) begin
            s_d.tx_tick[c] = tx_rise[c];
         end else begin
            s_d.tx_tick[c] = i_tx_tick_int[c];
         end
         if (rx_ext[c]) begin
            s_d.rx_tick[c] = rx_rise[c];
         end else if (rx_from_tx[c] && tx_ext[c]) begin
            s_d.rx_tick[c] = tx_rise[c];
         end else begin
            s_d.rx_tick[c] = i_rx_tick_int[c];
         end
         // baud toggle, so pin frequency is half the tick rate
         if ((dtr_clk_sel[c] == CLK_SEL_DTR_1X && s_d.tx_tick[c]) ||
             (dtr_clk_sel[c] == CLK_SEL_DTR_NX && i_tx_tick_nx[c])) begin
            s_d.clk_out[c] = ~s_q.clk_out[c];
         end
         // ri low rings unless the pin serves as a clock
         s_d.ring[c] = ~i_ri_n[c] & ~tx_ext[c];
         // dtr pin: clock out, then rs485 direction, then flow
         if (dtr_clk_sel[c] == CLK_SEL_DTR_1X ||
             dtr_clk_sel[c] == CLK_SEL_DTR_NX) begin
            s_d.dtr_n[c] = s_d.clk_out[c];
         end else begin
            case (i_additional_control_reg_dtr[c])
               ADD_CTL_DTR_485_HI: s_d.dtr_n[c] = ~i_tx_empty[c];
               ADD_CTL_DTR_485_LO: s_d.dtr_n[c] = i_tx_empty[c];
               default: begin
                  if (i_auto_dtr[c]) begin
                     s_d.dtr_n[c] = ~s_d.dtr_flow[c];
                  end else begin
                     s_d.dtr_n[c] = ~i_modem_control_reg[c][MODEM_CTL_DTR_BIT];
                  end
               end
            endcase
         end
         if (i_auto_rts[c]) begin
            s_d.rts_n[c] = ~s_d.rts_flow[c];
         end else begin
            s_d.rts_n[c] = ~i_modem_control_reg[c][MODEM_CTL_RTS_BIT];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         s_q <= '0;
         s_q.dtr_flow <= RST_DTR_FLOW;
         s_q.rts_flow <= RST_RTS_FLOW;
         s_q.dtr_n <= RST_PIN_N;
         s_q.rts_n <= RST_PIN_N;
         s_q.depth <= {NUM_CH{DEPTH_SMALL}};
      end else begin
         s_q <= s_d;
      end
   end

   // =========================================================
   // outputs
   assign o_dtr_n = s_q.dtr_n;
   assign o_rts_n = s_q.rts_n;
   assign o_tx_tick = s_q.tx_tick;
   assign o_rx_tick = s_q.rx_tick;
   assign o_ring_present = s_q.ring;
   assign o_fifo_depth = s_q.depth;
   // gates only starts; a character already running always finishes
   assign o_tx_start_ok = ~s_q.stop | i_tx_flow_char;

   // =========================================================
   // checks
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_chk
         chk_dtr_flow_on: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            i_auto_dtr[g] && at_upper[g] && dtr_clk_sel[g] == 2'h0 &&
            !i_additional_control_reg_dtr[g][1] |=> !o_dtr_n[g])
            else $error("auto dtr not asserted at upper level");
         chk_dtr_flow_off: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            i_auto_dtr[g] && !at_upper[g] && below_lower[g] &&
            dtr_clk_sel[g] == 2'h0 &&
            !i_additional_control_reg_dtr[g][1] |=> o_dtr_n[g])
            else $error("auto dtr not released below lower level");
         chk_dtr_rs485_dir: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            dtr_clk_sel[g] == 2'h0 &&
            i_additional_control_reg_dtr[g] == ADD_CTL_DTR_485_HI
            |=> o_dtr_n[g] == !$past(i_tx_empty[g]))
            else $error("rs485 direction does not track empty");
         chk_rts_flow_off: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            i_auto_rts[g] && at_upper[g] |=> o_rts_n[g])
            else $error("auto rts not dropped at upper level");
         chk_rts_flow_on: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            i_auto_rts[g] && !at_upper[g] && below_lower[g]
            |=> !o_rts_n[g])
            else $error("auto rts not restored below lower level");
         chk_cts_hold_tx: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            i_auto_cts[g] && i_cts_n[g] ##1 !i_tx_flow_char[g]
            |-> !o_tx_start_ok[g])
            else $error("start allowed while cts deasserted");
         chk_dsr_hold_tx: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            i_auto_dsr[g] && i_dsr_n[g] && !rx_ext[g]
            ##1 !i_tx_flow_char[g] |-> !o_tx_start_ok[g])
            else $error("start allowed while dsr deasserted");
         chk_flow_char_go: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            i_tx_flow_char[g] |-> o_tx_start_ok[g])
            else $error("flow character held by modem lines");
         chk_rx_ext_clk: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            rx_ext[g] && !$past(i_srst) && i_dsr_n[g] && !$past(i_dsr_n[g])
            |=> o_rx_tick[g])
            else $error("receive tick missing on dsr clock edge");
         chk_tx_ext_clk: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            tx_ext[g] && !$past(i_srst) &&
            !(i_ri_n[g] && !$past(i_ri_n[g])) |=> !o_tx_tick[g])
            else $error("transmit tick without ri clock edge");
         chk_ring_low: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            !i_ri_n[g] && !tx_ext[g] |=> o_ring_present[g])
            else $error("low ri not reported as ring");
         chk_fifo_big: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            i_fifo_size_select |=> o_fifo_depth[g] == DEPTH_BIG)
            else $error("fifo depth not 128 with size select");
         chk_fifo_small: assert property (@(posedge i_clk_sys)
            disable iff (i_srst)
            !i_fifo_size_select && !i_fifo_force128[g] && !i_enhanced[g]
            |=> o_fifo_depth[g] == DEPTH_SMALL)
            else $error("fifo depth not 16 by default");
      end
   endgenerate
endmodule : umf_top

/* rtl/umf_pkg.sv */
// Functional notes
// - auto dtr asserts at upper, drops below lower
// - rs485 mode: dtr follows transmitter empty
// - dtr pin can carry 1x or nx tx clock
// - auto rts drops at upper, returns below lower
// - cts deasserted: finish character, then idle
// - dsr deasserted: finish character, then idle
// - xon/xoff characters bypass cts/dsr hold
// - clock select 01: receiver uses dsr clock
// - clock select bit 6: transmitter uses ri clock
// - modem pins active low, ri low rings
// - fifo depth 16, or 128 when selected
// - modem control bit 6, in enhanced mode only: infrared serial coding
package umf_pkg;
   // =========================================================
   // channel count and fifo depth
   localparam int NUM_CH = 4;
   localparam logic [7:0] DEPTH_SMALL = 8'h10;
   localparam logic [7:0] DEPTH_BIG = 8'h80;

   // =========================================================
   // register field positions
   localparam int MODEM_CTL_DTR_BIT = 0;
   localparam int MODEM_CTL_RTS_BIT = 1;
   localparam int MODEM_CTL_IR_BIT = 6;
   localparam int CLK_SEL_RX_LO = 0;
   localparam int CLK_SEL_DTR_LO = 4;
   localparam int CLK_SEL_TX_EXT_BIT = 6;

   // =========================================================
   // field encodings
   localparam logic [1:0] CLK_SEL_RX_EXT = 2'h1;
   localparam logic [1:0] CLK_SEL_RX_FROM_TX = 2'h2;
   localparam logic [1:0] CLK_SEL_DTR_1X = 2'h1;
   localparam logic [1:0] CLK_SEL_DTR_NX = 2'h2;
   localparam logic [1:0] ADD_CTL_DTR_485_HI = 2'h2;
   localparam logic [1:0] ADD_CTL_DTR_485_LO = 2'h3;

   // =========================================================
   // infrared timing, in 16x ticks
   localparam logic [3:0] IRDA_PULSE_TICKS = 4'h3;
   localparam logic [3:0] IRDA_RX_HOLD = 4'hf;

   // =========================================================
   // reset values
   localparam logic [3:0] RST_DTR_FLOW = 4'h0;
   localparam logic [3:0] RST_RTS_FLOW = 4'hf;
   localparam logic [3:0] RST_PIN_N = 4'hf;

   // =========================================================
   // state types
   typedef struct packed {
      logic [3:0] dtr_flow;
      logic [3:0] rts_flow;
      logic [3:0] dtr_n;
      logic [3:0] rts_n;
      logic [3:0] stop;
      logic [3:0] rx_tick;
      logic [3:0] tx_tick;
      logic [3:0] ring;
      logic [3:0] clk_out;
      logic [3:0][7:0] depth;
   } umf_top_st_t;

   typedef struct packed {
      logic [3:0] tx_cnt;
      logic [3:0] rx_cnt;
      logic sout;
      logic rx_bit;
   } umf_irda_st_t;

   typedef struct packed {
      logic prev;
   } umf_edge_st_t;
endpackage : umf_pkg

/* rtl/umf_pin_edge.sv */
`timescale 1ns/1ps
module umf_pin_edge import umf_pkg::*; (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // sampled clock pin
   input wire logic i_pin,
   // one-cycle enable on each rising edge
   output logic o_rise
);
   // =========================================================
   // edge detect
   umf_edge_st_t s_q;
   umf_edge_st_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.prev = i_pin;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         // idle modem pin is high; avoids a false edge after reset
         s_q.prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // pin is synchronous, so no extra stage; max rate is half i_clk_sys
   assign o_rise = i_pin & ~s_q.prev;
endmodule : umf_pin_edge

/* rtl/umf_irda.sv */
`timescale 1ns/1ps
module umf_irda import umf_pkg::*; (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // control
   input wire logic i_en,
   input wire logic i_tx_tick16,
   input wire logic i_rx_tick16,
   input wire logic i_bit_start,
   // transmit and receive bits
   input wire logic i_tx_bit,
   input wire logic i_sin,
   output logic o_sout,
   output logic o_rx_bit
);
   // =========================================================
   // encoder and pulse stretcher
   umf_irda_st_t s_q;
   umf_irda_st_t s_d;

   always_comb begin
      s_d = s_q;
      if (i_bit_start) begin
         s_d.tx_cnt = '0;
      end else if (i_tx_tick16 && s_q.tx_cnt != 4'hf) begin
         s_d.tx_cnt = s_q.tx_cnt + 4'h1;
      end
      // zero bit sends a short high pulse at bit start
      if (i_en) begin
         s_d.sout = ~i_tx_bit & (s_d.tx_cnt < IRDA_PULSE_TICKS);
      end else begin
         s_d.sout = i_tx_bit;
      end
      // a pulse is stretched into one whole zero bit
      if (!i_en) begin
         s_d.rx_cnt = '0;
         s_d.rx_bit = i_sin;
      end else if (i_sin) begin
         s_d.rx_cnt = IRDA_RX_HOLD;
         s_d.rx_bit = 1'b0;
      end else if (s_q.rx_cnt != 4'h0) begin
         if (i_rx_tick16) begin
            s_d.rx_cnt = s_q.rx_cnt - 4'h1;
         end
         s_d.rx_bit = 1'b0;
      end else begin
         s_d.rx_bit = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         s_q <= '0;
         s_q.sout <= 1'b1;
         s_q.rx_bit <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_sout = s_q.sout;
   assign o_rx_bit = s_q.rx_bit;

   // =========================================================
   // checks
   chk_irda_rx_pulse: assert property (@(posedge i_clk_sys)
      disable iff (i_srst) i_en && i_sin |=> !o_rx_bit)
      else $error("infrared pulse not decoded as zero");
   chk_irda_tx_plain: assert property (@(posedge i_clk_sys)
      disable iff (i_srst) !i_en |=> o_sout == $past(i_tx_bit))
      else $error("plain serial output differs from bit");
   chk_irda_one_dark: assert property (@(posedge i_clk_sys)
      disable iff (i_srst) i_en && i_tx_bit |=> !o_sout)
      else $error("infrared one bit emitted a pulse");
endmodule : umf_irda

/* bench/umf_far_model.sv */
`timescale 1ns/1ps
// =====
// far-side modem: handshake levels and burst clocks
module umf_far_model (
   // clock
   input wire logic i_clk_sys,
   // requests from the bench
   input wire logic [3:0] i_cts_off,
   input wire logic [3:0] i_dsr_off,
   input wire logic [3:0] i_ring,
   input wire logic [3:0] i_dsr_clk,
   input wire logic [3:0] i_ri_clk,
   input wire logic i_slow,
   // modem pins, active low
   output logic [3:0] o_cts_n,
   output logic [3:0] o_dsr_n,
   output logic [3:0] o_ri_n
);
   logic [3:0][2:0] ph_q = '0;
   logic [3:0] clk_lvl;
   // clocks run only in bursts, starting and ending low
   always @(posedge i_clk_sys) begin
      for (int c = 0; c < 4; c++) begin
         ph_q[c] <= (i_dsr_clk[c] | i_ri_clk[c]) ? ph_q[c] + 3'h1 : 3'h0;
      end
   end
   // slow option: period of 8 cycles instead of 4
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         clk_lvl[c] = i_slow ? ph_q[c][2] : ph_q[c][1];
      end
   end
   // deasserted handshake is driven high, never left floating
   assign o_cts_n = i_cts_off;
   assign o_dsr_n = (i_dsr_clk & clk_lvl) | (~i_dsr_clk & i_dsr_off);
   assign o_ri_n = (i_ri_clk & clk_lvl) | (~i_ri_clk & ~i_ring);
endmodule : umf_far_model

/* bench/umf_top_tb.sv */
`timescale 1ns/1ps
module umf_top_tb import umf_pkg::*;;
   typedef struct packed {
      logic [3:0] kind;
      logic [31:0] val;
   } umf_tb_exp_t;
   logic i_clk_sys = 1'b0;
   logic i_srst = 1'b1;
   logic [3:0] cts_n, dsr_n, ri_n, dtr_n, rts_n, sout, start_ok, tx_tick;
   logic [3:0] rx_tick, rx_bit, ring_present;
   logic [3:0][7:0] depth;
   logic [3:0] sin = 4'hf, tbit = 4'h0, tx_empty = 4'h0, flow_char = 4'h0;
   logic [3:0] tti = 4'h0, ttn = 4'h0, rti = 4'h0, rt16 = 4'h0;
   logic [3:0] tbs = 4'h0, tt16 = 4'h0;
   logic [3:0] f128 = 4'h0, enh = 4'h0, a_dtr = 4'h0, a_rts = 4'h0;
   logic [3:0] a_cts = 4'h0, a_dsr = 4'h0, cts_off = 4'h0, dsr_off = 4'h0;
   logic [3:0] ring = 4'h0, dsr_clk = 4'h0, ri_clk = 4'h0, ev;
   logic fsel = 1'b0, slow = 1'b0, dprev = 1'b1, hi;
   logic [3:0][7:0] level = '0, upper = '0, lower = '0, clock_select_reg = '0, modem_control_reg = '0;
   logic [3:0][1:0] additional_control_reg = '0;
   logic [31:0] r, dv32;
   umf_tb_exp_t exq[$];
   int bad_count = 0;
   int n_tests = 0;
   int rxc = 0, txc = 0, dchg = 0, mch = 0;

   umf_top dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
      .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_ri_n(ri_n),
      .o_dtr_n(dtr_n), .o_rts_n(rts_n), .i_sin(sin), .o_sout(sout),
      .i_tx_bit(tbit), .i_tx_bit_start(tbs), .i_tx_empty(tx_empty),
      .i_tx_flow_char(flow_char), .i_tx_tick_int(tti), .i_tx_tick_nx(ttn),
      .i_tx_tick16(tt16), .o_tx_start_ok(start_ok), .o_tx_tick(tx_tick),
      .i_rx_tick_int(rti), .i_rx_tick16(rt16), .i_rx_level(level),
      .o_rx_tick(rx_tick), .o_rx_bit(rx_bit), .i_fifo_size_select(fsel),
      .i_fifo_force128(f128), .i_enhanced(enh), .o_fifo_depth(depth),
      .i_auto_dtr(a_dtr), .i_auto_rts(a_rts), .i_auto_cts(a_cts),
      .i_auto_dsr(a_dsr), .i_thr_upper(upper), .i_thr_lower(lower),
      .i_additional_control_reg_dtr(additional_control_reg), .i_clock_select_reg(clock_select_reg),
      .i_modem_control_reg(modem_control_reg), .o_ring_present(ring_present));

   umf_far_model far (.i_clk_sys(i_clk_sys), .i_cts_off(cts_off),
      .i_dsr_off(dsr_off), .i_ring(ring), .i_dsr_clk(dsr_clk),
      .i_ri_clk(ri_clk), .i_slow(slow), .o_cts_n(cts_n), .o_dsr_n(dsr_n),
      .o_ri_n(ri_n));

   initial begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   // =====
   // result watcher and pulse counters
   task automatic cmp_pin(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : cmp_pin
   task automatic cmp_cnt(input int g, input logic [31:0] x);
      cmp_pin(32'(g), x);
   endtask : cmp_cnt
   always begin : watch
      umf_tb_exp_t e;
      wait (exq.size() != 0);
      e = exq.pop_front();
      case (e.kind)
         4'h0: cmp_pin({28'h0, rts_n}, e.val);
         4'h1: cmp_pin({28'h0, dtr_n}, e.val);
         4'h2: cmp_pin({28'h0, start_ok}, e.val);
         4'h3: cmp_pin(depth, e.val);
         4'h4: cmp_cnt(rxc, e.val);
         4'h5: cmp_cnt(txc, e.val);
         4'h6: cmp_cnt(dchg, e.val);
         4'h7: cmp_pin({28'h0, ring_present}, e.val);
         4'h8: cmp_pin({28'h0, rx_bit}, e.val);
         default: cmp_pin({28'h0, sout}, e.val);
      endcase
   end
   always @(posedge i_clk_sys) begin
      rxc = rxc + ((rx_tick[mch] === 1'b1) ? 1 : 0);
      txc = txc + ((tx_tick[mch] === 1'b1) ? 1 : 0);
      dchg = dchg + ((dtr_n[mch] !== dprev) ? 1 : 0);
      dprev = dtr_n[mch];
   end

   // =====
   // driver helpers
   task automatic put(input logic [3:0] k, input logic [31:0] v);
      exq.push_back('{kind: k, val: v});
   endtask : put
   task automatic settle();
      @(posedge i_clk_sys);
      #1;
   endtask : settle
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask : cyc
   task automatic clr();
      @(negedge i_clk_sys);
      rxc = 0;
      txc = 0;
      dchg = 0;
      dprev = dtr_n[mch];
   endtask : clr
   task automatic pulse(input int w, input int c);
      @(negedge i_clk_sys);
      case (w)
         0: tti[c] = 1'b1;
         1: ttn[c] = 1'b1;
         2: rti[c] = 1'b1;
         4: tt16[c] = 1'b1;
         default: rt16[c] = 1'b1;
      endcase
      @(negedge i_clk_sys);
      tt16 = 4'h0;
      tti = 4'h0;
      ttn = 4'h0;
      rti = 4'h0;
      rt16 = 4'h0;
   endtask : pulse
   // far clock burst of n cycles, with internal ticks mixed in
   task automatic run_clk(input logic use_ri, input int n, input int k,
                          input int w);
      @(negedge i_clk_sys);
      if (use_ri) ri_clk[mch] = 1'b1;
      else dsr_clk[mch] = 1'b1;
      for (int i = 0; i < k; i++) pulse(w, mch);
      cyc(n - 2 * k);
      ri_clk = 4'h0;
      dsr_clk = 4'h0;
      cyc(6);
   endtask : run_clk
   task automatic end_sim();
      if (bad_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   initial begin
      #100us;
      bad_count++;
      end_sim();
   end

   // =====
   // main sequence
   initial begin
      void'($urandom(1776));
      @(posedge i_clk_sys);
      settle();
      put(1, 32'hf);
      put(0, 32'hf);
      put(3, 32'h10101010);
      put(9, 32'hf);
      @(negedge i_clk_sys);
      i_srst = 1'b0;
      for (int c = 0; c < 4; c++) begin
         lower[c] = 8'(2 + $urandom_range(60));
         upper[c] = lower[c] + 8'(4 + $urandom_range(60));
         a_dtr[c] = 1'b1;
         a_rts[c] = 1'b1;
         for (int s = 0; s < 5; s++) begin
            @(negedge i_clk_sys);
            level[c] = (s == 0) ? 8'h00 : (s == 1) ? upper[c] - 8'h01 :
               (s == 2) ? upper[c] : (s == 3) ? lower[c] : lower[c] - 8'h01;
            hi = (s == 2 || s == 3);
            settle();
            ev = 4'hf;
            for (int k = 0; k < c; k++) ev[k] = 1'b0;
            ev[c] = hi;
            put(0, {28'h0, ev});
            ev = 4'hf;
            ev[c] = ~hi;
            put(1, {28'h0, ev});
         end
      end
      @(negedge i_clk_sys);
      a_dtr = 4'h0;
      for (int m = 2; m < 4; m++) begin
         for (int e = 0; e < 2; e++) begin
            @(negedge i_clk_sys);
            additional_control_reg[1] = 2'(m);
            tx_empty[1] = e[0];
            settle();
            ev = 4'hf;
            ev[1] = (m == 2) ? ~e[0] : e[0];
            put(1, {28'h0, ev});
         end
      end
      @(negedge i_clk_sys);
      additional_control_reg[1] = 2'h0;
      a_cts[0] = 1'b1;
      a_dsr[0] = 1'b1;
      for (int i = 0; i < 2; i++) begin
         @(negedge i_clk_sys);
         if (i == 0) cts_off[0] = 1'b1;
         else dsr_off[0] = 1'b1;
         settle();
         put(2, 32'he);
         @(negedge i_clk_sys);
         flow_char[0] = 1'b1;
         #1;
         put(2, 32'hf);
         @(negedge i_clk_sys);
         flow_char[0] = 1'b0;
         cts_off = 4'h0;
         dsr_off = 4'h0;
         settle();
         put(2, 32'hf);
      end
      repeat (4) begin
         @(negedge i_clk_sys);
         r = $urandom;
         ring = r[3:0];
         settle();
         put(7, {28'h0, r[3:0]});
      end
      repeat (12) begin
         @(negedge i_clk_sys);
         r = $urandom;
         fsel = r[8];
         f128 = r[3:0];
         enh = r[7:4];
         settle();
         for (int c = 0; c < 4; c++)
            dv32[c*8 +: 8] = (r[8] | r[c] | r[4+c]) ? DEPTH_BIG : DEPTH_SMALL;
         put(3, dv32);
      end
      @(negedge i_clk_sys);
      ring = 4'h0;
      mch = 2;
      clock_select_reg[2] = 8'h10;
      cyc(3);
      clr();
      repeat (5) pulse(0, 2);
      cyc(3);
      put(6, 32'd5);
      clock_select_reg[2] = 8'h20;
      cyc(3);
      clr();
      for (int i = 0; i < 6; i++) begin
         pulse(1, 2);
         if (i % 2 == 0) pulse(0, 2);
      end
      cyc(3);
      put(6, 32'd6);
      clock_select_reg[2] = 8'h00;
      mch = 3;
      clock_select_reg[3] = 8'h01;
      clr();
      run_clk(1'b0, 16, 2, 2);
      put(4, 32'd4);
      slow = 1'b1;
      clr();
      run_clk(1'b0, 32, 3, 2);
      put(4, 32'd4);
      slow = 1'b0;
      clock_select_reg[3] = 8'h00;
      clr();
      run_clk(1'b0, 16, 3, 2);
      put(4, 32'd3);
      ring[3] = 1'b1;
      clock_select_reg[3] = 8'h40;
      clr();
      run_clk(1'b1, 16, 2, 0);
      put(5, 32'd4);
      clock_select_reg[3] = 8'h00;
      clr();
      run_clk(1'b1, 16, 3, 0);
      put(5, 32'd3);
      ring = 4'h0;
      fsel = 1'b0;
      f128 = 4'h0;
      enh = 4'h1;
      modem_control_reg[0] = 8'h40;
      sin[0] = 1'b0;
      cyc(3);
      sin[0] = 1'b1;
      settle();
      put(8, 32'he);
      @(negedge i_clk_sys);
      sin[0] = 1'b0;
      repeat (20) pulse(3, 0);
      cyc(2);
      put(8, 32'hf);
      @(negedge i_clk_sys);
      tbs[0] = 1'b1;
      settle();
      put(9, 32'h1);
      @(negedge i_clk_sys);
      tbs[0] = 1'b0;
      repeat (3) pulse(4, 0);
      settle();
      put(9, 32'h0);
      @(negedge i_clk_sys);
      tbit = 4'hf;
      settle();
      put(9, 32'he);
      cyc(4);
      end_sim();
   end
endmodule : umf_top_tb
